/* File: rtl/psr_pkg.sv */
// constants of the peripheral soft reset controller
// assumes a 25 MHz system clock and word-aligned Avalon-MM byte addresses
//
// Functional notes
// - group a writes masked by capability one
// - group b writes masked by capability two
// - both groups reset to all zeros
// - group a bit 24 resets bus controller
// - group a bit 16 resets converter zero
// - group a bit 6 resets sleep keeper
// - group a bit 3 resets watchdog
// - group b bits 25,24 reset comparators
// - group b bits 19..16 reset counters
// - group b bits 14,12 reset two-wire units
// - group b bits 5,4 reset sync serial
// - group b bits 1,0 reset async serial
// - unassigned bits read-only, read zero
// - group b at 0x044, group a 0x040
// - ungated unit disabled, access faults
package psr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // addressing
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_GROUP_A = 12'h040;
    localparam logic [11:0] OFF_GROUP_B = 12'h044;
    localparam logic [11:0] OFF_FAULT = 12'h050;

    ////////////////////////////////////////////////////////////////////////
    // reset values and implemented-field masks
    localparam logic [31:0] RESET_GROUP_A = 32'h00000000;
    localparam logic [31:0] RESET_GROUP_B = 32'h00000000;
    localparam logic [1:0] RESET_FAULT = 2'h0;
    localparam logic [31:0] FIELD_A = 32'h01010048;
    localparam logic [31:0] FIELD_B = 32'h030F5033;

    ////////////////////////////////////////////////////////////////////////
    // bit positions, group a
    localparam int BIT_BUSCTL0 = 24;
    localparam int BIT_CONV0 = 16;
    localparam int BIT_SLEEPK = 6;
    localparam int BIT_WDOG = 3;
    // bit positions, group b
    localparam int BIT_CMP1 = 25;
    localparam int BIT_CMP0 = 24;
    localparam int BIT_GPC0 = 16;
    localparam int BIT_TWI1 = 14;
    localparam int BIT_TWI0 = 12;
    localparam int BIT_SYNC1 = 5;
    localparam int BIT_SYNC0 = 4;
    localparam int BIT_ASYNC1 = 1;
    localparam int BIT_ASYNC0 = 0;
    // fault status bits
    localparam int FAULT_BIT_A = 0;
    localparam int FAULT_BIT_B = 1;

    ////////////////////////////////////////////////////////////////////////
    // avalon response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: rtl/psr_bus_if.sv */
// request path between the avalon front end and the register bank
// assumes both ends run on clk_sys
`timescale 1ns/1ps
interface psr_bus_if;
    logic valid;
    logic write;
    logic commit;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic [31:0] rdata;
    logic err;

    modport front (
        output valid, write, commit, addr, wdata, be,
        input rdata, err
    );
    modport regs (
        input valid, write, commit, addr, wdata, be,
        output rdata, err
    );
endinterface

/* File: rtl/psr_avs.sv */
// avalon-mm slave front end with one wait state
// assumes a master that holds its request until waitrequest is low
`timescale 1ns/1ps
module psr_avs (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    psr_bus_if.front bus
);

    logic wait_q;
    logic wait_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [1:0] resp_q;
    logic [1:0] resp_d;
    wire req = avs_read | avs_write;
    wire launch = req & wait_q;

    ////////////////////////////////////////////////////////////////////////
    // request passes straight to the register bank
    assign bus.valid = req;
    assign bus.write = avs_write;
    assign bus.addr = avs_address;
    assign bus.wdata = avs_writedata;
    assign bus.be = avs_byteenable;
    assign bus.commit = req & ~wait_q; // edge where master sees wait low

    // next values: drop wait for one cycle after each new request
    assign wait_d = launch ? 1'b0 : 1'b1;
    assign rdata_d = launch ? (avs_read ? bus.rdata : 32'h00000000)
                            : rdata_q;
    assign resp_d = launch ? (bus.err ? psr_pkg::RESP_SLVERR
                                      : psr_pkg::RESP_OKAY) : resp_q;

    // answer registers
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
            resp_q <= psr_pkg::RESP_OKAY;
        end else begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
            resp_q <= resp_d;
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata = rdata_q;
    assign avs_response = resp_q;

    ////////////////////////////////////////////////////////////////////////
    // wait state lasts exactly one cycle
    a_wait_one_cycle: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        launch |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest not low for exactly one cycle");

endmodule

/* File: rtl/psr_top.sv */
// peripheral soft reset controller: two reset groups, fault status
// assumes capability, clock gate and access inputs come from clk_sys logic
`timescale 1ns/1ps
module psr_top (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    input wire logic [31:0] capability_word_one,
    input wire logic [31:0] capability_word_two,
    input wire logic [31:0] clock_gate_a,
    input wire logic [31:0] clock_gate_b,
    input wire logic [31:0] unit_access_a,
    input wire logic [31:0] unit_access_b,
    output logic [31:0] unit_clock_en_a,
    output logic [31:0] unit_clock_en_b,
    output logic unit_bus_fault,
    output logic bus_controller_zero_reset,
    output logic converter_zero_reset,
    output logic sleep_keeper_reset,
    output logic watchdog_reset,
    output logic comparator_one_reset,
    output logic comparator_zero_reset,
    output logic gp_counter_three_reset,
    output logic gp_counter_two_reset,
    output logic gp_counter_one_reset,
    output logic gp_counter_zero_reset,
    output logic twowire_one_reset,
    output logic twowire_zero_reset,
    output logic sync_serial_one_reset,
    output logic sync_serial_zero_reset,
    output logic async_serial_one_reset,
    output logic async_serial_zero_reset
);

    ////////////////////////////////////////////////////////////////////////
    // byte-lane merge limited to the bits allowed to change
    function automatic logic [31:0] merge_word(
        input logic [31:0] old_word,
        input logic [31:0] new_word,
        input logic [3:0] lanes,
        input logic [31:0] allowed
    );
        logic [31:0] m;
        m = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};
        m = m & allowed;
        return (old_word & ~m) | (new_word & m);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // front end
    psr_bus_if bus ();

    psr_avs u_avs (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response),
        .bus(bus.front)
    );

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [31:0] group_a_q;
    logic [31:0] group_a_d;
    logic [31:0] group_b_q;
    logic [31:0] group_b_d;
    logic [1:0] fault_q;
    logic [1:0] fault_d;
    logic [31:0] clk_en_a_q;
    logic [31:0] clk_en_b_q;
    logic bus_fault_q;

    ////////////////////////////////////////////////////////////////////////
    // address decode
    // register offsets decoded
    wire hit_a = (bus.addr == psr_pkg::OFF_GROUP_A);
    wire hit_b = (bus.addr == psr_pkg::OFF_GROUP_B);
    wire hit_f = (bus.addr == psr_pkg::OFF_FAULT);
    wire wr_a = bus.commit & bus.write & hit_a;
    wire wr_b = bus.commit & bus.write & hit_b;
    wire wr_f = bus.commit & bus.write & hit_f;

    // read mux, unmapped addresses read zero and answer an error
    // unassigned bits read zero
    wire [31:0] rd_word = hit_a ? (group_a_q & psr_pkg::FIELD_A) :
                          hit_b ? (group_b_q & psr_pkg::FIELD_B) :
                          hit_f ? {30'h00000000, fault_q} :
                          32'h00000000;
    assign bus.rdata = rd_word;
    assign bus.err = ~(hit_a | hit_b | hit_f);

    ////////////////////////////////////////////////////////////////////////
    // next reset words, capability masks the writable bits
    // capability one masks group a
    wire [31:0] allow_a = capability_word_one & psr_pkg::FIELD_A;
    wire [31:0] allow_b = capability_word_two & psr_pkg::FIELD_B;
    assign group_a_d = wr_a ?
        merge_word(group_a_q, bus.wdata, bus.be, allow_a) : group_a_q;
    assign group_b_d = wr_b ?
        merge_word(group_b_q, bus.wdata, bus.be, allow_b) : group_b_q;

    ////////////////////////////////////////////////////////////////////////
    // gated-unit access detection
    // access to unclocked unit faults
    wire [31:0] bad_a = unit_access_a & ~clock_gate_a & psr_pkg::FIELD_A;
    wire [31:0] bad_b = unit_access_b & ~clock_gate_b & psr_pkg::FIELD_B;
    wire set_fa = |bad_a;
    wire set_fb = |bad_b;
    wire [1:0] fault_set = {set_fb, set_fa};
    wire [1:0] fault_clr = wr_f & bus.be[0] ? bus.wdata[1:0] : 2'h0;
    // write one to clear, a new fault in the same cycle wins
    assign fault_d = (fault_q & ~fault_clr) | fault_set;

    ////////////////////////////////////////////////////////////////////////
    // reset control registers
    // zero after system reset
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            group_a_q <= psr_pkg::RESET_GROUP_A;
            group_b_q <= psr_pkg::RESET_GROUP_B;
        end else begin
            group_a_q <= group_a_d;
            group_b_q <= group_b_d;
        end
    end

    // clock enables, fault pulse and sticky fault status
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            clk_en_a_q <= 32'h00000000;
            clk_en_b_q <= 32'h00000000;
            bus_fault_q <= 1'b0;
            fault_q <= psr_pkg::RESET_FAULT;
        end else begin
            clk_en_a_q <= clock_gate_a & psr_pkg::FIELD_A;
            clk_en_b_q <= clock_gate_b & psr_pkg::FIELD_B;
            bus_fault_q <= set_fa | set_fb;
            fault_q <= fault_d;
        end
    end

    assign unit_clock_en_a = clk_en_a_q;
    assign unit_clock_en_b = clk_en_b_q;
    assign unit_bus_fault = bus_fault_q;

    ////////////////////////////////////////////////////////////////////////
    // per-unit reset outputs, held while the bit is set
    // bit drives unit reset
    assign bus_controller_zero_reset = group_a_q[psr_pkg::BIT_BUSCTL0];
    assign converter_zero_reset = group_a_q[psr_pkg::BIT_CONV0];
    assign sleep_keeper_reset = group_a_q[psr_pkg::BIT_SLEEPK];
    assign watchdog_reset = group_a_q[psr_pkg::BIT_WDOG];
    assign comparator_one_reset = group_b_q[psr_pkg::BIT_CMP1];
    assign comparator_zero_reset = group_b_q[psr_pkg::BIT_CMP0];
    assign gp_counter_three_reset = group_b_q[psr_pkg::BIT_GPC0 + 3];
    assign gp_counter_two_reset = group_b_q[psr_pkg::BIT_GPC0 + 2];
    assign gp_counter_one_reset = group_b_q[psr_pkg::BIT_GPC0 + 1];
    assign gp_counter_zero_reset = group_b_q[psr_pkg::BIT_GPC0];
    assign twowire_one_reset = group_b_q[psr_pkg::BIT_TWI1];
    assign twowire_zero_reset = group_b_q[psr_pkg::BIT_TWI0];
    assign sync_serial_one_reset = group_b_q[psr_pkg::BIT_SYNC1];
    assign sync_serial_zero_reset = group_b_q[psr_pkg::BIT_SYNC0];
    assign async_serial_one_reset = group_b_q[psr_pkg::BIT_ASYNC1];
    assign async_serial_zero_reset = group_b_q[psr_pkg::BIT_ASYNC0];

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_group_a_cap: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wr_a |=> ((group_a_q ^ $past(group_a_q))
                  & ~$past(capability_word_one)) == 32'h00000000)
        else $error("group a bit changed without capability");

    a_group_b_cap: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wr_b |=> ((group_b_q ^ $past(group_b_q))
                  & ~$past(capability_word_two)) == 32'h00000000)
        else $error("group b bit changed without capability");

    a_reset_zero: assert property (
        @(posedge clk_sys)
        !reset_n |=> group_a_q == 32'h00000000
                     && group_b_q == 32'h00000000 && !unit_bus_fault)
        else $error("reset words not zero after reset");

    a_busctl_bit: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wr_a && bus.be[3] && capability_word_one[24]
        |=> bus_controller_zero_reset == $past(bus.wdata[24]))
        else $error("bus controller reset bit wrong");

    a_conv_bit: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wr_a && bus.be[2] && capability_word_one[16]
        |=> converter_zero_reset == $past(bus.wdata[16]))
        else $error("converter reset bit wrong");

    a_sleepk_bit: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wr_a && bus.be[0] && capability_word_one[6]
        |=> sleep_keeper_reset == $past(bus.wdata[6]))
        else $error("sleep keeper reset bit wrong");

    a_wdog_bit: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wr_a && bus.be[0] && capability_word_one[3]
        |=> watchdog_reset == $past(bus.wdata[3]))
        else $error("watchdog reset bit wrong");

    a_cmp_bits: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wr_b && bus.be[3] && (&capability_word_two[25:24])
        |=> {comparator_one_reset, comparator_zero_reset}
            == $past(bus.wdata[25:24]))
        else $error("comparator reset bits wrong");

    a_gpc_bits: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wr_b && bus.be[2] && (&capability_word_two[19:16])
        |=> {gp_counter_three_reset, gp_counter_two_reset,
             gp_counter_one_reset, gp_counter_zero_reset}
            == $past(bus.wdata[19:16]))
        else $error("counter reset bits wrong");

    a_twi_bits: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wr_b && bus.be[1] && capability_word_two[14]
        && capability_word_two[12]
        |=> twowire_one_reset == $past(bus.wdata[14])
            && twowire_zero_reset == $past(bus.wdata[12]))
        else $error("two-wire reset bits wrong");

    a_sync_bits: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wr_b && bus.be[0] && (&capability_word_two[5:4])
        |=> {sync_serial_one_reset, sync_serial_zero_reset}
            == $past(bus.wdata[5:4]))
        else $error("sync serial reset bits wrong");

    a_async_bits: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wr_b && bus.be[0] && (&capability_word_two[1:0])
        |=> {async_serial_one_reset, async_serial_zero_reset}
            == $past(bus.wdata[1:0]))
        else $error("async serial reset bits wrong");

    a_reserved_zero: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (group_a_q & ~psr_pkg::FIELD_A) == 32'h00000000
        && (group_b_q & ~psr_pkg::FIELD_B) == 32'h00000000)
        else $error("reserved reset bit set");

    // read of offset 0x044 returns the group b word
    a_offset_read: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        bus.valid && !bus.write && bus.addr == 12'h044
        |-> rd_word == group_b_q && !bus.err)
        else $error("offset 0x044 does not read group b");

    // writes elsewhere leave group a alone
    a_offset_write: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        bus.commit && bus.addr != 12'h040 |=> $stable(group_a_q))
        else $error("group a changed by other offset");

    // clearing releases on the next clock
    a_release_next: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        wr_a && bus.be[0] && !bus.wdata[3] && watchdog_reset
        && capability_word_one[psr_pkg::BIT_WDOG]
        |=> !watchdog_reset)
        else $error("watchdog not released after clear");

    a_reset_hold: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        !bus.commit |=> $stable(group_a_q) && $stable(group_b_q))
        else $error("reset word changed without a write");

    // gated access raises fault pulse and status
    a_gated_fault: assert property (
        @(posedge clk_sys) disable iff (!reset_n)
        (set_fa || set_fb) |=> unit_bus_fault && (fault_q != 2'h0))
        else $error("gated access did not fault");

    // main scenarios
    c_set_busctl: cover property (
        @(posedge clk_sys) disable iff (!reset_n)
        wr_a ##1 bus_controller_zero_reset);
    c_masked_write: cover property (
        @(posedge clk_sys) disable iff (!reset_n)
        wr_b && bus.be[0] && bus.wdata[0] && !capability_word_two[0]);
    c_unmapped: cover property (
        @(posedge clk_sys) disable iff (!reset_n)
        bus.valid && bus.err);
    c_fault_clear_race: cover property (
        @(posedge clk_sys) disable iff (!reset_n)
        set_fa && fault_clr[0]);

endmodule

/* File: test/testbench.sv */
// self-checking bench for the peripheral soft reset controller
// assumes psr_pkg and psr_top are compiled first; one 25 MHz clock
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [11:0] avs_address = 12'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] capability_word_one, capability_word_two;
    logic [31:0] clock_gate_a, clock_gate_b, unit_access_a, unit_access_b;
    logic [31:0] avs_readdata, unit_clock_en_a, unit_clock_en_b;
    logic [1:0] avs_response;
    logic avs_waitrequest, unit_bus_fault;
    logic bus_controller_zero_reset, converter_zero_reset;
    logic sleep_keeper_reset, watchdog_reset;
    logic comparator_one_reset, comparator_zero_reset;
    logic gp_counter_three_reset, gp_counter_two_reset;
    logic gp_counter_one_reset, gp_counter_zero_reset;
    logic twowire_one_reset, twowire_zero_reset;
    logic sync_serial_one_reset, sync_serial_zero_reset;
    logic async_serial_one_reset, async_serial_zero_reset;
    logic [31:0] exp_a = 32'h00000000;
    logic [31:0] exp_b = 32'h00000000;
    logic [11:0] addr;
    int n_mismatch = 0;
    int checked = 0;
    int seed_val;

    psr_top psr_top_inst (.clk_sys, .reset_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .avs_response, .capability_word_one,
        .capability_word_two, .clock_gate_a, .clock_gate_b,
        .unit_access_a, .unit_access_b, .unit_clock_en_a,
        .unit_clock_en_b, .unit_bus_fault, .bus_controller_zero_reset,
        .converter_zero_reset, .sleep_keeper_reset, .watchdog_reset,
        .comparator_one_reset, .comparator_zero_reset,
        .gp_counter_three_reset, .gp_counter_two_reset,
        .gp_counter_one_reset, .gp_counter_zero_reset,
        .twowire_one_reset, .twowire_zero_reset, .sync_serial_one_reset,
        .sync_serial_zero_reset, .async_serial_one_reset,
        .async_serial_zero_reset);

    ////////////////////////////////////////////////////////////////////////
    // clock, 40 ns period
    always #20 clk_sys = ~clk_sys;

    // verdict and end of run
    task automatic test_done;
        if (n_mismatch == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // compare seen against expected
    task automatic chk(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // byte lanes to bit mask
    function automatic logic [31:0] lane_m(input logic [3:0] be);
        lane_m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus_op(input logic wr, input logic [11:0] a,
            input logic [31:0] wd, input logic [3:0] be,
            output logic [31:0] rd, output logic [1:0] rsp);
        @(posedge clk_sys);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= wd;
        avs_byteenable <= be;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        rsp = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // reset outputs and clock enables against the model, one edge later
    task automatic check_outs;
        @(posedge clk_sys);
        chk("busctl reset", bus_controller_zero_reset, exp_a[24]);
        chk("conv reset", converter_zero_reset, exp_a[16]);
        chk("sleep reset", sleep_keeper_reset, exp_a[6]);
        chk("wdog reset", watchdog_reset, exp_a[3]);
        chk("cmp reset", {comparator_one_reset,
            comparator_zero_reset}, exp_b[25:24]);
        chk("gpc reset", {gp_counter_three_reset,
            gp_counter_two_reset, gp_counter_one_reset,
            gp_counter_zero_reset}, exp_b[19:16]);
        chk("twi reset", {twowire_one_reset, twowire_zero_reset},
            {exp_b[14], exp_b[12]});
        chk("sync reset", {sync_serial_one_reset,
            sync_serial_zero_reset}, exp_b[5:4]);
        chk("async reset", {async_serial_one_reset,
            async_serial_zero_reset}, exp_b[1:0]);
        chk("clk en a", unit_clock_en_a,
            clock_gate_a & psr_pkg::FIELD_A);
        chk("clk en b", unit_clock_en_b,
            clock_gate_b & psr_pkg::FIELD_B);
    endtask

    // write, then update the model with the masks then in force
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] wd,
            input logic [3:0] be);
        logic [31:0] m;
        logic [31:0] d;
        logic [1:0] r;
        bus_op(1'b1, a, wd, be, d, r);
        m = lane_m(be);
        if (a == psr_pkg::OFF_GROUP_A) begin
            m = m & psr_pkg::FIELD_A & capability_word_one;
            exp_a = (exp_a & ~m) | (wd & m);
        end
        if (a == psr_pkg::OFF_GROUP_B) begin
            m = m & psr_pkg::FIELD_B & capability_word_two;
            exp_b = (exp_b & ~m) | (wd & m);
        end
        check_outs();
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp,
            input logic [1:0] exp_r);
        logic [31:0] d;
        logic [1:0] r;
        bus_op(1'b0, a, 32'h00000000, 4'hF, d, r);
        chk("read data", d, exp);
        chk("read response", {30'h0, r}, {30'h0, exp_r});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // watchdog: the sequence needs about 800 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        test_done();
    end

    // main sequence
    initial begin
        {capability_word_one, capability_word_two} <= 64'h0;
        {clock_gate_a, clock_gate_b, unit_access_a, unit_access_b} <= 128'h0;
        seed_val = $urandom(32'h90F89FFE);
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd_chk(psr_pkg::OFF_GROUP_A, 32'h0, psr_pkg::RESP_OKAY);
        rd_chk(psr_pkg::OFF_GROUP_B, 32'h0, psr_pkg::RESP_OKAY);
        check_outs();
        // corners: full write, then write under zero capability
        for (int i = 0; i < 64; i++) begin
            capability_word_one <= (i < 2) ? 32'hFFFFFFFF :
                (i < 4) ? 32'h00000000 : $urandom | $urandom;
            capability_word_two <= (i < 2) ? 32'hFFFFFFFF :
                (i < 4) ? 32'h00000000 : $urandom | $urandom;
            clock_gate_a <= $urandom;
            clock_gate_b <= $urandom;
            addr = i[0] ? psr_pkg::OFF_GROUP_B : psr_pkg::OFF_GROUP_A;
            wr_reg(addr, (i < 2) ? 32'hFFFFFFFF : (i < 4) ? 32'h0 : $urandom,
                (i < 4) ? 4'hF : 4'($urandom));
            rd_chk(psr_pkg::OFF_GROUP_A, exp_a, psr_pkg::RESP_OKAY);
            rd_chk(psr_pkg::OFF_GROUP_B, exp_b, psr_pkg::RESP_OKAY);
        end
        // unmapped places answer an error and hold nothing
        for (int k = 0; k < 12; k++) begin
            // skips the fault word at 0x050, which is mapped
            addr = (k < 2) ? 12'h048 + 12'(k * 4) : 12'h054 + 12'(k * 8);
            wr_reg(addr, 32'hFFFFFFFF, 4'hF);
            rd_chk(addr, 32'h00000000, psr_pkg::RESP_SLVERR);
        end
        rd_chk(psr_pkg::OFF_GROUP_A, exp_a, psr_pkg::RESP_OKAY);
        // gated access faults once, status sticky, write one clears
        for (int g = 0; g < 3; g++) begin
            @(posedge clk_sys);
            clock_gate_a <= (g == 2) ? 32'hFFFFFFFF : 32'h0;
            clock_gate_b <= 32'h0;
            unit_access_a <= (g == 1) ? 32'h0 : 32'h8;
            unit_access_b <= (g == 1) ? 32'h2 : 32'h0;
            @(posedge clk_sys);
            unit_access_a <= 32'h0;
            unit_access_b <= 32'h0;
            @(posedge clk_sys);
            chk("fault pulse", unit_bus_fault, g != 2);
            @(posedge clk_sys);
            chk("fault end", unit_bus_fault, 1'b0);
            rd_chk(psr_pkg::OFF_FAULT, (g == 2) ? 0 : (1 << g),
                psr_pkg::RESP_OKAY);
            wr_reg(psr_pkg::OFF_FAULT, 32'h3, 4'h1);
            rd_chk(psr_pkg::OFF_FAULT, 32'h0, psr_pkg::RESP_OKAY);
        end
        // load both words, so the second reset has something to clear
        capability_word_one <= 32'hFFFFFFFF;
        capability_word_two <= 32'hFFFFFFFF;
        wr_reg(psr_pkg::OFF_GROUP_A, 32'hFFFFFFFF, 4'hF);
        wr_reg(psr_pkg::OFF_GROUP_B, 32'hFFFFFFFF, 4'hF);
        // second reset in mid-run clears both words
        @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        reset_n <= 1'b1;
        exp_a = 32'h00000000;
        exp_b = 32'h00000000;
        rd_chk(psr_pkg::OFF_GROUP_A, 32'h0, psr_pkg::RESP_OKAY);
        rd_chk(psr_pkg::OFF_GROUP_B, 32'h0, psr_pkg::RESP_OKAY);
        check_outs();
        test_done();
    end
endmodule
